/* include/rf_wake_pkg.sv */
// Purpose: shared constants and carriers for the network and wake-up configuration block
// Assumes: core clock of 10 MHz, binary commands delivered as parallel words
// Notes: every offset, reset value and timing figure lives here by name

package rf_wake_pkg;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_DELAY = 8'h03;
  localparam logic [7:0] CMD_LENGTH = 8'h0C;
  localparam logic [7:0] CMD_CHANNEL = 8'h11;
  localparam logic [7:0] CMD_VENDOR = 8'h27;

  // ----------------------------------------
  // reset values and ranges
  // ----------------------------------------
  localparam logic [15:0] DELAY_RST = 16'hFFFF;
  localparam logic [15:0] DELAY_NEVER = 16'hFFFF;
  localparam logic [7:0] LENGTH_RST = 8'h01;
  localparam logic [7:0] LENGTH_NONE = 8'h00;
  localparam logic [7:0] CHANNEL_RST = 8'h00;
  localparam logic [7:0] CHANNEL_MAX = 8'h06;
  localparam logic [15:0] VID_USER_MIN = 16'h0010;
  localparam logic [15:0] VID_USER_MAX = 16'h7FFF;
  localparam logic [15:0] VID_FACTORY_MIN = 16'h8000;
  // arbitrary neutral value
  localparam logic [15:0] VID_DFLT = 16'h3C5A;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam int HOP_SEQS = 7;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int TICK_MS = 100;
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_MS = 1000000;
  localparam int TICK_CYCLES_DFLT = TICK_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int LISTEN_CYCLES = 32;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] code;
    logic write;
    logic [15:0] data;
  } cmd_s;

  typedef struct packed {
    logic err;
    logic [15:0] data;
  } rsp_s;

  typedef struct packed {
    logic [15:0] network_vendor_value;
    logic [7:0] channel;
  } frame_hdr_s;

  typedef enum {TX_IDLE, TX_INIT, TX_DATA} tx_state_e;
  typedef enum {RX_AWAKE, RX_SLEEP, RX_LISTEN} rx_state_e;

endpackage : rf_wake_pkg

/* src/unit_ticker.sv */
// Purpose: one-cycle tick every CYCLES clocks, restartable
// Assumes: synchronous active-low reset
// Notes: clear restarts the period so the next tick is a full unit away
`timescale 1ns/1ps

module unit_ticker #(
  parameter int CYCLES = 1000000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // control
  input wire logic clear,
  output logic tick
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // period counter next value
  always_comb begin
    if (clear || cnt_q == LAST) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // tick is a one-cycle strobe, held low while clear is high
  assign tick = !clear && cnt_q == LAST;

endmodule : unit_ticker

/* src/rf_network_wakeup_config.sv */
// Purpose: hop channel, vendor ident and wake-up initializer control of the radio
// Assumes: commands arrive as parsed binary words; radio signals are synchronous
// Notes: counts of 100 ms units come from unit_ticker; TICK_CYCLES shortens them
`timescale 1ns/1ps

module rf_network_wakeup_config #(
  parameter int TICK_CYCLES = rf_wake_pkg::TICK_CYCLES_DFLT,
  parameter logic [15:0] VID_INIT = rf_wake_pkg::VID_DFLT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // binary command port
  input wire logic cmd_valid,
  input wire rf_wake_pkg::cmd_s cmd,
  output logic rsp_valid,
  output rf_wake_pkg::rsp_s rsp,
  // network configuration to the radio
  output logic [7:0] hop_channel_select,
  output logic [rf_wake_pkg::HOP_SEQS-1:0] hop_sequence_sel,
  output rf_wake_pkg::frame_hdr_s tx_header,
  // transmit path
  input wire logic tx_pending,
  input wire logic tx_done,
  output logic tx_start,
  output logic init_active,
  output logic init_due,
  // receive filter
  input wire logic rx_hdr_valid,
  input wire rf_wake_pkg::frame_hdr_s rx_hdr,
  output logic rx_accept,
  output logic rx_discard,
  // receive sleep control
  input wire logic cyclic_sleep_en,
  input wire logic [15:0] inactivity_sleep_timeout,
  input wire logic [15:0] sleep_interval,
  input wire logic rx_activity,
  input wire logic init_detect,
  output logic low_power,
  output logic rx_listen
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // channel legality, used by the command path and the sequence decode
  function automatic logic chan_ok(input logic [7:0] c);
    chan_ok = c <= rf_wake_pkg::CHANNEL_MAX;
  endfunction : chan_ok

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == rf_wake_pkg::CNT_MAX) ? v : v + 16'h0001;
  endfunction : sat_inc

  // ----------------------------------------
  // configuration registers and command port
  // ----------------------------------------
  logic [15:0] delay_q, delay_d;
  logic [7:0] length_q, length_d;
  logic [7:0] chan_q, chan_d;
  logic [15:0] vid_q, vid_d;
  logic rsp_valid_q, rsp_valid_d;
  rf_wake_pkg::rsp_s rsp_q, rsp_d;
  logic wr;

  assign wr = cmd_valid && cmd.write;

  // command decode and next configuration
  always_comb begin
    delay_d = delay_q;
    length_d = length_q;
    chan_d = chan_q;
    vid_d = vid_q;
    rsp_valid_d = cmd_valid;
    rsp_d = '0;
    if (cmd_valid) begin
      case (cmd.code)
        rf_wake_pkg::CMD_CHANNEL: begin
          rsp_d.data = {8'h00, chan_q};
          if (wr) begin
            if (cmd.data[15:8] == 8'h00 && chan_ok(cmd.data[7:0])) begin
              chan_d = cmd.data[7:0];
            end else begin
              rsp_d.err = 1'b1;
            end
          end
        end
        rf_wake_pkg::CMD_DELAY: begin
          rsp_d.data = delay_q;
          if (wr) begin
            delay_d = cmd.data;
          end
        end
        rf_wake_pkg::CMD_LENGTH: begin
          rsp_d.data = {8'h00, length_q};
          if (wr) begin
            if (cmd.data[15:8] == 8'h00) begin
              length_d = cmd.data[7:0];
            end else begin
              rsp_d.err = 1'b1;
            end
          end
        end
        rf_wake_pkg::CMD_VENDOR: begin
          rsp_d.data = vid_q;
          if (wr) begin
            // factory values lock the ident; users may only pick the low range
            if (vid_q < rf_wake_pkg::VID_FACTORY_MIN &&
                cmd.data >= rf_wake_pkg::VID_USER_MIN &&
                cmd.data <= rf_wake_pkg::VID_USER_MAX) begin
              vid_d = cmd.data;
            end else begin
              rsp_d.err = 1'b1;
            end
          end
        end
        default: begin
          rsp_d.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      delay_q <= rf_wake_pkg::DELAY_RST;
      length_q <= rf_wake_pkg::LENGTH_RST;
      chan_q <= rf_wake_pkg::CHANNEL_RST;
      vid_q <= VID_INIT;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      delay_q <= delay_d;
      length_q <= length_d;
      chan_q <= chan_d;
      vid_q <= vid_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign hop_channel_select = chan_q;
  assign tx_header = '{network_vendor_value: vid_q, channel: chan_q};

  // ----------------------------------------
  // hop sequence select
  // ----------------------------------------
  // one sequence per channel
  genvar g;
  generate
    for (g = 0; g < rf_wake_pkg::HOP_SEQS; g++) begin : g_seq
      assign hop_sequence_sel[g] = chan_ok(chan_q) && chan_q == 8'(g);
    end
  endgenerate

  // ----------------------------------------
  // receive filter
  // ----------------------------------------
  logic rx_accept_q, rx_accept_d;
  logic rx_discard_q, rx_discard_d;
  logic hdr_match;

  assign hdr_match = rx_hdr.network_vendor_value == vid_q && rx_hdr.channel == chan_q;

  always_comb begin
    rx_accept_d = rx_hdr_valid && hdr_match;
    rx_discard_d = rx_hdr_valid && !hdr_match;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_accept_q <= 1'b0;
      rx_discard_q <= 1'b0;
    end else begin
      rx_accept_q <= rx_accept_d;
      rx_discard_q <= rx_discard_d;
    end
  end

  assign rx_accept = rx_accept_q;
  assign rx_discard = rx_discard_q;

  // ----------------------------------------
  // transmit side: idle timer and initializer
  // ----------------------------------------
  rf_wake_pkg::tx_state_e tx_st_q, tx_st_d;
  logic [15:0] idle_q, idle_d;
  logic [7:0] init_left_q, init_left_d;
  logic tx_start_q, tx_start_d;
  logic tx_tick;
  logic tx_clear;
  logic due;

  // restart the unit on tx completion and whenever a send request leaves idle
  assign tx_clear = (tx_st_q == rf_wake_pkg::TX_DATA && tx_done) ||
                    (tx_st_q == rf_wake_pkg::TX_IDLE && tx_pending);

  unit_ticker #(
    .CYCLES(TICK_CYCLES)
  ) u_tx_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .clear(tx_clear),
    .tick(tx_tick)
  );

  // never due at the all-ones delay
  // due once the delay has passed
  assign due = delay_q != rf_wake_pkg::DELAY_NEVER && idle_q >= delay_q;

  always_comb begin
    tx_st_d = tx_st_q;
    idle_d = idle_q;
    init_left_d = init_left_q;
    tx_start_d = 1'b0;
    case (tx_st_q)
      rf_wake_pkg::TX_IDLE: begin
        if (tx_tick) begin
          idle_d = sat_inc(idle_q);
        end
        if (tx_pending) begin
          if (due && length_q != rf_wake_pkg::LENGTH_NONE) begin
            tx_st_d = rf_wake_pkg::TX_INIT;
            init_left_d = length_q;
          end else begin
            tx_st_d = rf_wake_pkg::TX_DATA;
            tx_start_d = 1'b1;
          end
        end
      end
      rf_wake_pkg::TX_INIT: begin
        if (tx_tick) begin
          init_left_d = init_left_q - 8'h01;
          if (init_left_q == 8'h01) begin
            tx_st_d = rf_wake_pkg::TX_DATA;
            tx_start_d = 1'b1;
          end
        end
      end
      rf_wake_pkg::TX_DATA: begin
        if (tx_done) begin
          tx_st_d = rf_wake_pkg::TX_IDLE;
          idle_d = '0;
        end
      end
      default: begin
        tx_st_d = rf_wake_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_st_q <= rf_wake_pkg::TX_IDLE;
      idle_q <= '0;
      init_left_q <= '0;
      tx_start_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      idle_q <= idle_d;
      init_left_q <= init_left_d;
      tx_start_q <= tx_start_d;
    end
  end

  assign tx_start = tx_start_q;
  assign init_active = tx_st_q == rf_wake_pkg::TX_INIT;
  // flag only meaningful for sends that have not started yet
  assign init_due = due;

  // ----------------------------------------
  // receive side: cyclic sleep
  // ----------------------------------------
  rf_wake_pkg::rx_state_e rx_st_q, rx_st_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] lis_q, lis_d;
  logic rx_tick;
  logic rx_clear;

  // activity or a state change starts a fresh unit
  assign rx_clear = rx_activity || rx_st_d != rx_st_q;

  unit_ticker #(
    .CYCLES(TICK_CYCLES)
  ) u_rx_tick (
    .core_clk(core_clk),
    .resetn(resetn),
    .clear(rx_clear),
    .tick(rx_tick)
  );

  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    lis_d = lis_q;
    case (rx_st_q)
      rf_wake_pkg::RX_AWAKE: begin
        if (rx_activity) begin
          rx_cnt_d = '0;
        end else if (cyclic_sleep_en && rx_cnt_q >= inactivity_sleep_timeout) begin
          rx_st_d = rf_wake_pkg::RX_SLEEP;
          rx_cnt_d = '0;
        end else if (rx_tick) begin
          rx_cnt_d = sat_inc(rx_cnt_q);
        end
      end
      rf_wake_pkg::RX_SLEEP: begin
        if (!cyclic_sleep_en) begin
          rx_st_d = rf_wake_pkg::RX_AWAKE;
          rx_cnt_d = '0;
        end else if (rx_cnt_q >= sleep_interval) begin
          rx_st_d = rf_wake_pkg::RX_LISTEN;
          lis_d = '0;
        end else if (rx_tick) begin
          rx_cnt_d = sat_inc(rx_cnt_q);
        end
      end
      rf_wake_pkg::RX_LISTEN: begin
        if (init_detect || !cyclic_sleep_en) begin
          rx_st_d = rf_wake_pkg::RX_AWAKE;
          rx_cnt_d = '0;
        end else if (lis_q == 8'(rf_wake_pkg::LISTEN_CYCLES - 1)) begin
          rx_st_d = rf_wake_pkg::RX_SLEEP;
          rx_cnt_d = '0;
        end else begin
          lis_d = lis_q + 8'h01;
        end
      end
      default: begin
        rx_st_d = rf_wake_pkg::RX_AWAKE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_st_q <= rf_wake_pkg::RX_AWAKE;
      rx_cnt_q <= '0;
      lis_q <= '0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      lis_q <= lis_d;
    end
  end

  assign low_power = rx_st_q == rf_wake_pkg::RX_SLEEP;
  assign rx_listen = rx_st_q == rf_wake_pkg::RX_LISTEN;

endmodule : rf_network_wakeup_config

/* verif/rf_wake_properties.sv */
// Purpose: port relations of the wake-up configuration block
// Assumes: one clock, synchronous active-low reset
// Notes: bound from tb_top
`timescale 1ns/1ps

module rf_wake_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // command port
  input wire logic cmd_valid,
  input wire rf_wake_pkg::cmd_s cmd,
  input wire logic rsp_valid,
  input wire rf_wake_pkg::rsp_s rsp,
  // radio side
  input wire logic [7:0] hop_channel_select,
  input wire logic [rf_wake_pkg::HOP_SEQS-1:0] hop_sequence_sel,
  input wire rf_wake_pkg::frame_hdr_s tx_header,
  input wire logic tx_start,
  input wire logic init_active,
  input wire logic rx_hdr_valid,
  input wire rf_wake_pkg::frame_hdr_s rx_hdr,
  input wire logic rx_accept,
  input wire logic rx_discard,
  input wire logic init_detect,
  input wire logic low_power,
  input wire logic rx_listen
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_chan_range: assert property (hop_channel_select <= 8'h06)
    else $error("channel outside range");
  a_seq_onehot: assert property ($onehot(hop_sequence_sel) &&
    hop_sequence_sel[hop_channel_select[2:0]]) else $error("sequence select wrong");
  a_rsp_follows: assert property (cmd_valid |=> rsp_valid)
    else $error("missing answer");
  a_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without command");
  a_bad_chan: assert property (cmd_valid && cmd.write && cmd.code == 8'h11 &&
    cmd.data > 16'h0006 |=> rsp.err && $stable(hop_channel_select))
    else $error("bad channel taken");
  a_hdr_chan: assert property (tx_header.channel == hop_channel_select)
    else $error("header channel differs");
  a_init_start: assert property ($fell(init_active) |-> tx_start)
    else $error("initializer end without start");
  a_start_pulse: assert property (tx_start |=> !tx_start)
    else $error("start longer than one cycle");
  a_rx_verdict: assert property (rx_hdr_valid |=> rx_accept != rx_discard)
    else $error("no single verdict");
  a_rx_match: assert property (rx_hdr_valid && rx_hdr == tx_header |=> rx_accept)
    else $error("matching header dropped");
  a_wake_init: assert property (rx_listen && init_detect |=> !low_power && !rx_listen)
    else $error("initializer did not wake");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_init_send: cover property ($fell(init_active) && tx_start);
  c_rx_drop: cover property (rx_hdr_valid ##1 rx_discard);
  c_wake: cover property (rx_listen && init_detect);
endmodule : rf_wake_properties

/* verif/radio_model.sv */
// Purpose: radio front end answering each start with a done pulse
// Assumes: start is a one-cycle pulse
// Notes: slow picks a long air time so both pacings are seen
`timescale 1ns/1ps

module radio_model (
  // clock
  input wire logic core_clk,
  // handshake
  input wire logic slow,
  input wire logic tx_start,
  output logic tx_done = 1'b0
);
  int left = 0;

  // air time countdown, done once it runs out
  always @(posedge core_clk) begin
    tx_done <= (left == 1);
    if (tx_start) begin
      left <= slow ? 12 : 2;
    end else if (left != 0) begin
      left <= left - 1;
    end
  end
endmodule : radio_model

/* verif/tb_top.sv */
// Purpose: self-checking bench of the wake-up configuration block
// Assumes: short unit of 4 cycles stands for 100 ms
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps

module tb_top;
  localparam int TICK = 4;
  // arbitrary value
  localparam logic [15:0] NETWORK_VENDOR_VALUE = 16'h2345;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  rf_wake_pkg::cmd_s cmd = '0;
  logic rsp_valid, tx_done, tx_start, init_active, init_due;
  rf_wake_pkg::rsp_s rsp;
  logic [7:0] hop_channel_select;
  logic [rf_wake_pkg::HOP_SEQS-1:0] hop_sequence_sel;
  rf_wake_pkg::frame_hdr_s tx_header;
  logic tx_pending = 1'b0;
  logic rx_hdr_valid = 1'b0;
  rf_wake_pkg::frame_hdr_s rx_hdr = '0;
  logic rx_accept, rx_discard, low_power, rx_listen;
  logic cyclic_sleep_en = 1'b0;
  // matches the initializer delay set on the sending side
  logic [15:0] inactivity_sleep_timeout = 16'h0002;
  logic [15:0] sleep_interval = 16'h0002;
  logic rx_activity = 1'b0;
  logic init_detect = 1'b0;
  logic slow = 1'b0;
  logic [15:0] rd;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int k, wn, inn;

  always #50 core_clk = ~core_clk;

  rf_network_wakeup_config #(.TICK_CYCLES(TICK), .VID_INIT(NETWORK_VENDOR_VALUE)) u_dut (.core_clk, .resetn,
    .cmd_valid, .cmd, .rsp_valid, .rsp, .hop_channel_select, .hop_sequence_sel, .tx_header,
    .tx_pending, .tx_done, .tx_start, .init_active, .init_due, .rx_hdr_valid, .rx_hdr,
    .rx_accept, .rx_discard, .cyclic_sleep_en, .inactivity_sleep_timeout, .sleep_interval,
    .rx_activity, .init_detect, .low_power, .rx_listen);

  radio_model u_radio (.core_clk, .slow, .tx_start, .tx_done);

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one command word, answer checked one cycle later
  task automatic send(input logic [7:0] code, input logic wr, input logic [15:0] data,
                      input logic err, output logic [15:0] q);
    tick(1);
    cmd_valid = 1'b1;
    cmd = '{code, wr, data};
    tick(1);
    cmd_valid = 1'b0;
    chk({rsp_valid, rsp.err}, {1'b1, err});
    q = rsp.data;
  endtask : send

  // one radio send; counts cycles to start and initializer cycles
  task automatic send_tx(output int w, output int n);
    w = 0;
    n = 0;
    tx_pending = 1'b1;
    while (tx_start !== 1'b1 && w < 3000) begin
      tick(1);
      w++;
      if (init_active === 1'b1) n++;
    end
    tx_pending = 1'b0;
    tick(16);
  endtask : send_tx

  task automatic rx(input logic [23:0] hdr, input logic [1:0] exp);
    // one idle edge so back-to-back headers never retoggle valid in one step
    tick(1);
    rx_hdr_valid = 1'b1;
    rx_hdr = hdr;
    tick(1);
    rx_hdr_valid = 1'b0;
    chk({rx_accept, rx_discard}, exp);
  endtask : rx

  task automatic finish_test();
    $display("n_errors=%0d samples_checked=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    tick(16);
    resetn = 1'b1;
    send(8'h03, 1'b0, 16'h0000, 1'b0, rd); chk(rd, 16'hFFFF);
    send(8'h0C, 1'b0, 16'h0000, 1'b0, rd); chk(rd, 16'h0001);
    send(8'h11, 1'b0, 16'h0000, 1'b0, rd); chk(rd, 16'h0000);
    send(8'h27, 1'b0, 16'h0000, 1'b0, rd); chk(rd, NETWORK_VENDOR_VALUE);
    send(8'h55, 1'b0, 16'h0000, 1'b1, rd);
    for (int c = 0; c < 7; c++) begin
      send(8'h11, 1'b1, 16'(c), 1'b0, rd);
      chk(hop_sequence_sel, 32'(1) << c);
      chk(tx_header.channel, c);
      chk(hop_channel_select, c);
    end
    send(8'h11, 1'b1, 16'h0007, 1'b1, rd);
    send(8'h11, 1'b1, 16'h0102, 1'b1, rd);
    send(8'h11, 1'b0, 16'h0000, 1'b0, rd); chk(rd, 16'h0006);
    send(8'h03, 1'b1, 16'h1234, 1'b0, rd);
    send(8'h03, 1'b0, 16'h0000, 1'b0, rd); chk(rd, 16'h1234);
    send(8'h0C, 1'b1, 16'h01FF, 1'b1, rd);
    send(8'h0C, 1'b1, 16'h00FF, 1'b0, rd);
    send(8'h0C, 1'b0, 16'h0000, 1'b0, rd); chk(rd, 16'h00FF);
    send(8'h27, 1'b1, 16'h000F, 1'b1, rd);
    send(8'h27, 1'b1, 16'h8000, 1'b1, rd);
    send(8'h27, 1'b1, 16'h0010, 1'b0, rd);
    send(8'h27, 1'b0, 16'h0000, 1'b0, rd); chk(rd, 16'h0010);
    chk(tx_header.network_vendor_value, 16'h0010);
    // peer headers: match, other vendor, other channel
    rx({16'h0010, 8'h06}, 2'b10);
    rx({16'h0011, 8'h06}, 2'b01);
    rx({16'h0010, 8'h05}, 2'b01);
    // delay at its never value: plain sends only
    send(8'h03, 1'b1, 16'hFFFF, 1'b0, rd);
    tick(40);
    chk(init_due, 1'b0);
    send_tx(wn, inn);
    chk(inn, 0);
    chk(wn < 3, 1'b1);
    // nonzero length, delay 0: always led by an initializer
    send(8'h0C, 1'b1, 16'h0002, 1'b0, rd);
    send(8'h03, 1'b1, 16'h0000, 1'b0, rd);
    send_tx(wn, inn);
    chk(inn, 2 * TICK);
    // delay of two units, slow radio
    send(8'h0C, 1'b1, 16'h0001, 1'b0, rd);
    send(8'h03, 1'b1, 16'h0002, 1'b0, rd);
    slow = 1'b1;
    tick(20);
    chk(init_due, 1'b1);
    send_tx(wn, inn);
    chk(inn, TICK);
    chk(init_due, 1'b0);
    tick(12);
    chk(init_due, 1'b1);
    // zero length: due, yet the send goes out with no initializer
    send(8'h0C, 1'b1, 16'h0000, 1'b0, rd);
    send_tx(wn, inn);
    chk(inn, 0);
    chk(wn < 3, 1'b1);
    // sleep: activity holds it awake, then sleep, listen and wake
    send(8'h0C, 1'b1, 16'h00FF, 1'b0, rd);
    cyclic_sleep_en = 1'b1;
    for (k = 0; k < 6; k++) begin
      rx_activity = 1'b1;
      tick(1);
      rx_activity = 1'b0;
      tick(1);
      chk(low_power, 1'b0);
    end
    for (k = 0; k < 60 && low_power !== 1'b1; k++) tick(1);
    chk(low_power, 1'b1);
    for (k = 0; k < 60 && rx_listen !== 1'b1; k++) tick(1);
    chk(rx_listen, 1'b1);
    // no initializer heard: back to low power after the listen window
    for (k = 0; k < 60 && low_power !== 1'b1; k++) tick(1);
    chk(k, rf_wake_pkg::LISTEN_CYCLES);
    chk(low_power, 1'b1);
    for (k = 0; k < 60 && rx_listen !== 1'b1; k++) tick(1);
    chk(rx_listen, 1'b1);
    init_detect = 1'b1;
    tick(2);
    init_detect = 1'b0;
    chk({low_power, rx_listen}, 2'b00);
    cyclic_sleep_en = 1'b0;
    tick(4);
    finish_test();
  end
endmodule : tb_top

bind rf_network_wakeup_config rf_wake_properties u_props (.core_clk, .resetn, .cmd_valid,
  .cmd, .rsp_valid, .rsp, .hop_channel_select, .hop_sequence_sel, .tx_header, .tx_start,
  .init_active, .rx_hdr_valid, .rx_hdr, .rx_accept, .rx_discard, .init_detect, .low_power,
  .rx_listen);
